// >>> src/pacc_unit.sv
`timescale 1ns/100ps
// accumulator and control operation unit; one op per i_op_valid when ready
module pacc_unit (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_op_valid,
  input wire pacc_pkg::pacc_op_e i_op,
  input wire logic i_cond,
  input wire logic [15:0] i_operand,
  input wire logic [31:0] i_acc_load,
  input wire logic i_acc_load_en,
  input wire logic [31:0] i_stack1,
  input wire logic [31:0] i_stack2,
  input wire logic i_prog_has_end,
  output logic o_op_ready,
  output logic [31:0] o_acc,
  output logic o_operand_range_flag,
  output logic o_run_mode,
  output logic o_no_end_error,
  output logic o_scan_done,
  output logic [2:0] o_rail_level,
  output logic o_rail_power,
  output logic o_rail_error,
  output logic o_mem_rd_req,
  output logic [15:0] o_mem_rd_addr,
  output logic o_mem_rd_label,
  input wire logic [15:0] i_mem_rd_data,
  output logic o_mem_wr_req,
  output logic [15:0] o_mem_wr_addr,
  output logic o_mem_wr_label,
  output logic [15:0] o_mem_wr_data,
  input wire logic i_mem_ready
);
  pacc_mem_if mem ();

  logic [31:0] acc_r;
  logic range_r, run_r, noend_r, scan_r, rail_err_r;
  logic [2:0] level_r;
  logic [7:0] rail_on_r;
  logic [31:0] enc, dec, decimal_to_radix2_convert, bcd;
  logic enc_multi, bcd_over, busy;

  assign o_mem_rd_req = mem.rd_req;
  assign o_mem_rd_addr = mem.rd_addr;
  assign o_mem_rd_label = mem.rd_label;
  assign o_mem_wr_req = mem.wr_req;
  assign o_mem_wr_addr = mem.wr_addr;
  assign o_mem_wr_label = mem.wr_label;
  assign o_mem_wr_data = mem.wr_data;
  assign mem.rd_data = i_mem_rd_data;
  assign mem.ready = i_mem_ready;

  pacc_convert u_conv (
    .i_acc(acc_r),
    .o_enc(enc),
    .o_enc_multi(enc_multi),
    .o_dec(dec),
    .o_bin(decimal_to_radix2_convert),
    .o_bcd(bcd),
    .o_bcd_over(bcd_over)
  );

  // copies hold the unit busy so a later op cannot disturb the captured stack
  wire take = i_op_valid && !busy;
  wire is_table = i_op == pacc_pkg::PACC_TABLE_COPY;
  wire is_label = i_op == pacc_pkg::PACC_LABEL_AREA_COPY;
  wire copy_go = take && i_cond && (is_table || is_label) && run_r;
  // table copy: count in level 1; label copy: count level 2, offset level 1
  wire [15:0] cp_count = is_label ? i_stack2[15:0] : i_stack1[15:0];
  wire [15:0] cp_offs = is_label ? i_stack1[15:0] : 16'h0000;
  wire count_bad = is_table && cp_count > pacc_pkg::COPY_MAX;
  wire [15:0] cp_src = 16'(acc_r[15:0] + cp_offs);
  wire [15:0] cp_dst = 16'(i_operand + cp_offs);
  // label source when the operand is a V address, i.e. label-to-V direction
  wire cp_from_label = is_label && acc_r[31];

  pacc_copy u_copy (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_start(copy_go && !count_bad),
    .i_label(cp_from_label),
    .i_dst_label(is_label && !acc_r[31]),
    .i_count(cp_count),
    .i_src(cp_src),
    .i_dst(cp_dst),
    .o_busy(busy),
    .mem(mem)
  );

  // rail power: every level up to the current one must be on
  // mask covers levels 0..current; rails above the current level do not matter
  wire [7:0] rail_mask = 8'hFF >> (3'h7 - level_r);
  wire rail_pow = &(rail_on_r | ~rail_mask);
  wire [2:0] open_n = i_operand[2:0];
  wire open_ok = i_operand[15:3] == 13'h0000 && open_n != 3'h0 &&
                 open_n <= pacc_pkg::RAIL_MAX && open_n == 3'(level_r + 3'h1);
  wire close_ok = i_operand[15:3] == 13'h0000 && level_r != 3'h0 &&
                  open_n == 3'(level_r - 3'h1);
  // ops in an unpowered section run as no-ops, except rail, scan and run-start control and the copy transfer (copy_go ignores rail power)
  wire gated = i_cond && rail_pow;

  assign o_op_ready = !busy;
  assign o_acc = acc_r;
  assign o_operand_range_flag = range_r;
  assign o_run_mode = run_r;
  assign o_no_end_error = noend_r;
  assign o_scan_done = scan_r;
  assign o_rail_level = level_r;
  assign o_rail_power = rail_pow;
  assign o_rail_error = rail_err_r;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      acc_r <= pacc_pkg::ACC_RST;
      range_r <= 1'b0;
      run_r <= 1'b0;
      noend_r <= 1'b0;
      scan_r <= 1'b0;
      level_r <= 3'h0;
      rail_on_r <= 8'h01;
      rail_err_r <= 1'b0;
    end else if (i_ce) begin
      scan_r <= 1'b0;
      if (i_acc_load_en && !busy) begin
        acc_r <= i_acc_load;
      end
      if (take) begin
        unique case (i_op)
          pacc_pkg::PACC_EMPTY_STEP: begin
          end
          pacc_pkg::PACC_BIT_POSITION_TO_INDEX: begin
            if (gated) begin
              acc_r <= enc;
              range_r <= enc_multi;
            end
          end
          pacc_pkg::PACC_INDEX_TO_ONE_HOT: begin
            if (gated) begin
              acc_r <= dec;
            end
          end
          pacc_pkg::PACC_DECIMAL_TO_RADIX2: begin
            if (gated) begin
              acc_r <= decimal_to_radix2_convert;
            end
          end
          pacc_pkg::PACC_RADIX2_TO_DECIMAL: begin
            if (gated) begin
              acc_r <= bcd;
              range_r <= bcd_over;
            end
          end
          pacc_pkg::PACC_ONES_COMPLEMENT: begin
            if (gated) begin
              acc_r <= ~acc_r;
            end
          end
          pacc_pkg::PACC_TABLE_COPY, pacc_pkg::PACC_LABEL_AREA_COPY: begin
            if (gated) begin
              range_r <= count_bad;
            end
          end
          pacc_pkg::PACC_END_MARK: begin
            scan_r <= 1'b1;
          end
          pacc_pkg::PACC_STOP: begin
            if (gated) begin
              run_r <= 1'b0;
            end
          end
          pacc_pkg::PACC_START_RUN: begin
            run_r <= i_prog_has_end;
            noend_r <= !i_prog_has_end;
          end
          pacc_pkg::PACC_RAIL_OPEN_LEVEL: begin
            if (open_ok) begin
              level_r <= open_n;
              rail_on_r[open_n] <= i_cond;
            end
            rail_err_r <= !open_ok;
          end
          pacc_pkg::PACC_RAIL_CLOSE_LEVEL: begin
            if (close_ok) begin
              rail_on_r[level_r] <= 1'b0;
              level_r <= open_n;
            end
            rail_err_r <= !close_ok;
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule : pacc_unit

// >>> inc/pacc_pkg.sv
// Behaviour
// - raise range flag on oversized operand
// - flags hold until same-flag op overwrites
// - encode replaces accumulator with bit index
// - several bits: lowest index, raise flag
// - encode result is five-bit index
// - decode index 0..31 to one-hot
// - index above 31 divided by 32 repeatedly
// - packed decimal to binary conversion
// - binary to packed decimal conversion
// - invert all 32 accumulator bits
// - table copy count at most 40 hex
// - copy count words source to destination
// - accumulator holds source, operand destination
// - no end marker: refuse run, report error
// - end marker is unconditional
// - stop with true condition enters program mode
// - empty location is a no-operation
// - main rail level zero; open makes level n
// - rails nest up to seven levels
// - close level is open level minus one
// - section logic needs all enclosing rails true
package pacc_pkg;
  localparam int ACC_W = 32;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 16;
  localparam logic [15:0] COPY_MAX = 16'h0040;
  localparam logic [2:0] RAIL_MAX = 3'h7;
  localparam logic [31:0] ACC_RST = 32'h0000_0000;
  localparam int DIGITS = 8;
  localparam int IDX_W = 5;

  typedef enum logic [3:0] {
    PACC_EMPTY_STEP,
    PACC_BIT_POSITION_TO_INDEX,
    PACC_INDEX_TO_ONE_HOT,
    PACC_DECIMAL_TO_RADIX2,
    PACC_RADIX2_TO_DECIMAL,
    PACC_ONES_COMPLEMENT,
    PACC_TABLE_COPY,
    PACC_LABEL_AREA_COPY,
    PACC_END_MARK,
    PACC_STOP,
    PACC_RAIL_OPEN_LEVEL,
    PACC_RAIL_CLOSE_LEVEL,
    PACC_START_RUN
  } pacc_op_e;

  typedef enum logic {
    PACC_MODE_PROGRAM,
    PACC_MODE_RUN
  } pacc_mode_e;
endpackage : pacc_pkg

// >>> inc/pacc_mem_if.sv
`timescale 1ns/100ps
// word-copy memory port between copy engine and top
interface pacc_mem_if;
  logic rd_req;
  logic [15:0] rd_addr;
  logic rd_label;
  logic [15:0] rd_data;
  logic wr_req;
  logic [15:0] wr_addr;
  logic wr_label;
  logic [15:0] wr_data;
  logic ready;
  modport engine (
    output rd_req, rd_addr, rd_label, wr_req, wr_addr, wr_label, wr_data,
    input rd_data, ready
  );
  modport port (
    input rd_req, rd_addr, rd_label, wr_req, wr_addr, wr_label, wr_data,
    output rd_data, ready
  );
endinterface : pacc_mem_if

// >>> src/pacc_convert.sv
`timescale 1ns/100ps
// pure combinational accumulator transforms
module pacc_convert (
  input wire logic [31:0] i_acc,
  output logic [31:0] o_enc,
  output logic o_enc_multi,
  output logic [31:0] o_dec,
  output logic [31:0] o_bin,
  output logic [31:0] o_bcd,
  output logic o_bcd_over
);
  function automatic logic [31:0] to_bin(input logic [31:0] d);
    logic [31:0] acc;
    acc = 32'h0000_0000;
    for (int k = pacc_pkg::DIGITS - 1; k >= 0; k--) begin
      acc = 32'(acc * 32'd10 + 32'(d[k*4 +: 4]));
    end
    return acc;
  endfunction : to_bin

  // shift-add-3, 40 bits wide so an 8-digit overflow is visible
  function automatic logic [39:0] to_bcd(input logic [31:0] b);
    logic [39:0] r;
    r = 40'h00_0000_0000;
    for (int i = 31; i >= 0; i--) begin
      for (int j = 0; j < 10; j++) begin
        if (r[j*4 +: 4] > 4'h4) begin
          r[j*4 +: 4] = 4'(r[j*4 +: 4] + 4'h3);
        end
      end
      r = {r[38:0], b[i]};
    end
    return r;
  endfunction : to_bcd

  logic [4:0] low_idx;
  logic [39:0] bcd_full;

  always_comb begin
    low_idx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (i_acc[i]) begin
        low_idx = 5'(i);
      end
    end
  end

  assign o_enc = {27'h000_0000, low_idx};
  assign o_enc_multi = (i_acc & (i_acc - 32'h0000_0001)) != 32'h0000_0000;
  // repeated division by 32 until below 32 leaves the top nonzero 5-bit group
  wire [4:0] dec_idx = (i_acc[31:30] != 2'h0) ? {3'h0, i_acc[31:30]} :
                       (i_acc[29:25] != 5'h00) ? i_acc[29:25] :
                       (i_acc[24:20] != 5'h00) ? i_acc[24:20] :
                       (i_acc[19:15] != 5'h00) ? i_acc[19:15] :
                       (i_acc[14:10] != 5'h00) ? i_acc[14:10] :
                       (i_acc[9:5] != 5'h00) ? i_acc[9:5] : i_acc[4:0];
  assign o_dec = 32'h0000_0001 << dec_idx;
  assign o_bin = to_bin(i_acc);
  assign bcd_full = to_bcd(i_acc);
  assign o_bcd = bcd_full[31:0];
  assign o_bcd_over = bcd_full[39:32] != 8'h00;
endmodule : pacc_convert

// >>> src/pacc_copy.sv
`timescale 1ns/100ps
// word-at-a-time copy sequencer
module pacc_copy (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_label,
  input wire logic i_dst_label,
  input wire logic [15:0] i_count,
  input wire logic [15:0] i_src,
  input wire logic [15:0] i_dst,
  output logic o_busy,
  pacc_mem_if.engine mem
);
  typedef enum logic [1:0] {CP_IDLE, CP_READ, CP_WRITE} pacc_cp_e;
  pacc_cp_e st_r;
  logic [15:0] left_r, src_r, dst_r, data_r;
  logic lab_r;
  logic wlab_r;

  assign o_busy = st_r != CP_IDLE;
  assign mem.rd_req = st_r == CP_READ;
  assign mem.rd_addr = src_r;
  assign mem.rd_label = lab_r;
  assign mem.wr_req = st_r == CP_WRITE;
  assign mem.wr_addr = dst_r;
  // destination area is fixed at start, independent of the source area
  assign mem.wr_label = wlab_r;
  assign mem.wr_data = data_r;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r <= CP_IDLE;
      left_r <= 16'h0000;
      src_r <= 16'h0000;
      dst_r <= 16'h0000;
      data_r <= 16'h0000;
      lab_r <= 1'b0;
      wlab_r <= 1'b0;
    end else if (i_ce) begin
      unique case (st_r)
        CP_IDLE: begin
          if (i_start && i_count != 16'h0000) begin
            left_r <= i_count;
            src_r <= i_src;
            dst_r <= i_dst;
            lab_r <= i_label;
            wlab_r <= i_dst_label;
            st_r <= CP_READ;
          end
        end
        CP_READ: begin
          if (mem.ready) begin
            data_r <= mem.rd_data;
            st_r <= CP_WRITE;
          end
        end
        CP_WRITE: begin
          if (mem.ready) begin
            src_r <= 16'(src_r + 16'h0001);
            dst_r <= 16'(dst_r + 16'h0001);
            left_r <= 16'(left_r - 16'h0001);
            st_r <= (left_r == 16'h0001) ? CP_IDLE : CP_READ;
          end
        end
      endcase
    end
  end
endmodule : pacc_copy

// >>> tb/pacc_unit_sva.sv
`timescale 1ns/100ps
module pacc_unit_sva (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_op_valid,
  input wire pacc_pkg::pacc_op_e i_op,
  input wire logic i_cond,
  input wire logic [15:0] i_operand,
  input wire logic i_acc_load_en,
  input wire logic [31:0] i_stack1,
  input wire logic i_prog_has_end,
  input wire logic o_op_ready,
  input wire logic [31:0] o_acc,
  input wire logic o_operand_range_flag,
  input wire logic o_run_mode,
  input wire logic o_no_end_error,
  input wire logic o_scan_done,
  input wire logic [2:0] o_rail_level,
  input wire logic o_rail_power,
  input wire logic o_rail_error,
  input wire logic o_mem_rd_req,
  input wire logic [15:0] o_mem_rd_addr,
  input wire logic o_mem_wr_req,
  input wire logic [15:0] o_mem_wr_data,
  input wire logic i_mem_ready
);
  wire take = i_ce && i_op_valid && o_op_ready;
  // a direct load in the same cycle would muddle the expected value
  wire live = take && i_cond && o_rail_power && !i_acc_load_en;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_op(pacc_pkg::pacc_op_e k);
    live && i_op == k;
  endsequence
  sequence s_any(pacc_pkg::pacc_op_e k);
    take && i_op == k;
  endsequence
  inv_result_a: assert property (s_op(pacc_pkg::PACC_ONES_COMPLEMENT)
    |=> o_acc == ~$past(o_acc)) else $error("invert result wrong");
  enc_multi_a: assert property (s_op(pacc_pkg::PACC_BIT_POSITION_TO_INDEX)
    ##0 ($countones(o_acc) > 1) |=> o_operand_range_flag && o_acc < 32'h0000_0020)
    else $error("encode of several bits wrong");
  dec_small_a: assert property (s_op(pacc_pkg::PACC_INDEX_TO_ONE_HOT)
    ##0 (o_acc < 32'h0000_0020) |=> o_acc == (32'h0000_0001 << $past(o_acc)))
    else $error("decode result wrong");
  scan_pulse_a: assert property (s_any(pacc_pkg::PACC_END_MARK) |=> o_scan_done)
    else $error("scan done missing");
  stop_mode_a: assert property (s_op(pacc_pkg::PACC_STOP) |=> !o_run_mode)
    else $error("stop left run mode on");
  no_end_a: assert property (s_any(pacc_pkg::PACC_START_RUN) ##0 !i_prog_has_end
    |=> !o_run_mode && o_no_end_error) else $error("run entered without end");
  rail_bad_a: assert property (s_any(pacc_pkg::PACC_RAIL_OPEN_LEVEL)
    ##0 (i_operand == 16'h0000) |=> o_rail_error && $stable(o_rail_level))
    else $error("bad rail level accepted");
  main_rail_a: assert property (o_rail_level == 3'h0 |-> o_rail_power)
    else $error("main rail unpowered");
  copy_range_a: assert property (s_op(pacc_pkg::PACC_TABLE_COPY) ##0 o_run_mode
    ##0 (i_stack1[15:0] > 16'h0040 && i_stack1[31:16] == 16'h0000)
    |=> o_operand_range_flag && !o_mem_rd_req) else $error("oversize copy started");
  rd_hold_a: assert property (o_mem_rd_req && !i_mem_ready
    |=> o_mem_rd_req && $stable(o_mem_rd_addr)) else $error("read request dropped");
  wr_hold_a: assert property (o_mem_wr_req && !i_mem_ready
    |=> o_mem_wr_req && $stable(o_mem_wr_data)) else $error("write request dropped");
endmodule : pacc_unit_sva

bind pacc_unit pacc_unit_sva i_pacc_unit_sva (.*);

// >>> tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  localparam logic [31:0] M = 32'h05f5_e100;
  logic i_clk = 0, i_srst = 1, i_ce = 1, i_op_valid = 0, i_cond = 1, i_acc_load_en = 0;
  logic i_prog_has_end = 0, i_mem_ready = 0;
  pacc_pkg::pacc_op_e i_op = pacc_pkg::PACC_EMPTY_STEP;
  logic [15:0] i_operand = 0, i_mem_rd_data = 0;
  logic [31:0] i_acc_load = 0, i_stack1 = 0, i_stack2 = 0;
  logic o_op_ready, o_operand_range_flag, o_run_mode, o_no_end_error, o_scan_done;
  logic o_rail_power, o_rail_error, o_mem_rd_req, o_mem_rd_label, o_mem_wr_req, o_mem_wr_label;
  logic [31:0] o_acc;
  logic [2:0] o_rail_level;
  logic [15:0] o_mem_rd_addr, o_mem_wr_addr, o_mem_wr_data, cs, cd;
  logic [31:0] lf = 32'h0000_32f3, v, ex;
  logic cl, wl, fx, c;
  int n_mismatch = 0, n_tests = 0, wn = 0, k;
  pacc_pkg::pacc_op_e ops [6] = '{pacc_pkg::PACC_BIT_POSITION_TO_INDEX,
    pacc_pkg::PACC_INDEX_TO_ONE_HOT, pacc_pkg::PACC_DECIMAL_TO_RADIX2,
    pacc_pkg::PACC_RADIX2_TO_DECIMAL, pacc_pkg::PACC_ONES_COMPLEMENT, pacc_pkg::PACC_EMPTY_STEP};
  pacc_unit i_pacc_unit (.*);
  initial forever #2.5 i_clk = ~i_clk;
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  function automatic logic [31:0] enc(input logic [31:0] s);
    logic [31:0] r = 0;
    for (int i = 31; i >= 0; i--) if (s[i]) r = i;
    return r;
  endfunction : enc
  function automatic logic [31:0] dec(input logic [31:0] s);
    while (s > 32'h0000_001f) s = s >> 5;
    return 32'h0000_0001 << s;
  endfunction : dec
  function automatic logic [31:0] bcd(input logic [31:0] s);
    logic [31:0] r = 0;
    for (int i = 0; i < 8; i++) begin
      r[4*i +: 4] = 4'(s % 4'ha);
      s = s / 4'ha;
    end
    return r;
  endfunction : bcd
  function automatic logic [15:0] md(input logic [15:0] a);
    return a ^ 16'h5a5a;
  endfunction : md
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic complete_run;
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic ld(input logic [31:0] a);
    @(posedge i_clk);
    i_acc_load <= a;
    i_acc_load_en <= 1'b1;
    @(posedge i_clk);
    i_acc_load_en <= 1'b0;
  endtask : ld
  task automatic op(input pacc_pkg::pacc_op_e o, input logic cc, input logic [15:0] d);
    @(posedge i_clk);
    i_op <= o;
    i_cond <= cc;
    i_operand <= d;
    i_op_valid <= 1'b1;
    @(posedge i_clk);
    i_op_valid <= 1'b0;
    @(negedge i_clk);
  endtask : op
  task automatic cp(input pacc_pkg::pacc_op_e o, input logic [31:0] s1, input logic [31:0] s2,
      input logic [31:0] a, input logic [15:0] d, input int n);
    logic [15:0] off;
    off = (o == pacc_pkg::PACC_LABEL_AREA_COPY) ? s1[15:0] : 16'h0000;
    cs = a[15:0] + off;
    cd = d + off;
    cl = a[31] && o == pacc_pkg::PACC_LABEL_AREA_COPY;
    wl = !a[31] && o == pacc_pkg::PACC_LABEL_AREA_COPY;
    wn = 0;
    ld(a);
    i_stack1 <= s1;
    i_stack2 <= s2;
    op(o, 1'b1, d);
    // stacks churn mid-copy: the copy must not notice
    for (int j = 0; j < 900 && (j == 0 || !o_op_ready); j++) begin
      @(posedge i_clk);
      lf = nx(lf);
      i_stack1 <= lf;
      i_stack2 <= lf;
    end
    @(negedge i_clk);
    cmp("copy words", n, wn);
  endtask : cp
  always @(posedge i_clk) begin
    if (o_mem_rd_req && i_mem_ready) begin
      cmp("rd_label", cl, o_mem_rd_label);
      cmp("rd_addr", cs + 16'(wn), o_mem_rd_addr);
    end
    if (o_mem_wr_req && i_mem_ready) begin
      cmp("wr_label", wl, o_mem_wr_label);
      cmp("wr_addr", cd + 16'(wn), o_mem_wr_addr);
      cmp("wr_data", md(cs + 16'(wn)), o_mem_wr_data);
      wn++;
    end
    i_mem_ready <= (o_mem_rd_req || o_mem_wr_req) && !i_mem_ready && lf[3];
    i_mem_rd_data <= o_mem_rd_req ? md(o_mem_rd_addr) : ~i_mem_rd_data;
  end
  initial begin
    #60000;
    n_mismatch++;
    complete_run;
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    @(negedge i_clk);
    cmp("rail_power", 1, o_rail_power);
    fx = 0;
    for (int t = 0; t < 60; t++) begin
      lf = nx(lf);
      k = t % 6;
      c = lf[12] | lf[13] | (t < 2);
      case (k)
        0: v = lf[5] ? 32'h0000_0001 << lf[4:0] : lf | 32'h0000_0003;
        1: v = lf[6] ? lf & 32'h0000_001f : lf;
        2: v = bcd(lf % M);
        3: v = lf[7] ? lf : lf % M;
        default: v = lf;
      endcase
      if (t == 0) v = 32'h8000_0000;
      if (t == 1) v = 32'h0000_0020;
      case (k)
        0: ex = enc(v);
        1: ex = dec(v);
        2: ex = lf % M;
        3: ex = bcd(v);
        4: ex = ~v;
        default: ex = v;
      endcase
      if (!c) ex = v;
      if (c && k == 0) fx = $countones(v) > 1;
      if (c && k == 3) fx = v >= M;
      ld(v);
      op(ops[k], c, 0);
      if (!(c && k == 3 && v >= M)) cmp("acc", ex, o_acc);
      if (k == 0 || k == 3 || k == 4) cmp("range_flag", fx, o_operand_range_flag);
    end
    op(pacc_pkg::PACC_START_RUN, 1'b1, 0);
    cmp("no_end_error", 1, o_no_end_error);
    cmp("run_mode", 0, o_run_mode);
    @(posedge i_clk);
    i_prog_has_end <= 1'b1;
    op(pacc_pkg::PACC_START_RUN, 1'b1, 0);
    cmp("run_mode", 1, o_run_mode);
    op(pacc_pkg::PACC_END_MARK, 1'b0, 0);
    cmp("scan_done", 1, o_scan_done);
    @(negedge i_clk);
    cmp("scan_done", 0, o_scan_done);
    cp(pacc_pkg::PACC_TABLE_COPY, 6, 0, 32'h0000_0100, 16'h0200, 6);
    cp(pacc_pkg::PACC_TABLE_COPY, 32'h0000_0040, 0, 32'h0000_0400, 16'h0800, 64);
    cp(pacc_pkg::PACC_TABLE_COPY, 32'h0000_0041, 0, 32'h0000_0100, 16'h0200, 0);
    cmp("range_flag", 1, o_operand_range_flag);
    cp(pacc_pkg::PACC_LABEL_AREA_COPY, 3, 4, 32'h8000_0010, 16'h0300, 4);
    cp(pacc_pkg::PACC_LABEL_AREA_COPY, 2, 3, 32'h0000_0020, 16'h0010, 3);
    op(pacc_pkg::PACC_STOP, 1'b1, 0);
    cmp("run_mode", 0, o_run_mode);
    cp(pacc_pkg::PACC_TABLE_COPY, 2, 0, 32'h0000_0100, 16'h0200, 0);
    op(pacc_pkg::PACC_RAIL_OPEN_LEVEL, 1'b1, 1);
    cmp("rail_level", 1, o_rail_level);
    op(pacc_pkg::PACC_RAIL_OPEN_LEVEL, 1'b0, 2);
    cmp("rail_power", 0, o_rail_power);
    ld(32'h0000_0005);
    op(pacc_pkg::PACC_ONES_COMPLEMENT, 1'b1, 0);
    cmp("acc", 5, o_acc);
    op(pacc_pkg::PACC_RAIL_OPEN_LEVEL, 1'b1, 0);
    cmp("rail_error", 1, o_rail_error);
    cmp("rail_level", 2, o_rail_level);
    op(pacc_pkg::PACC_RAIL_CLOSE_LEVEL, 1'b1, 1);
    cmp("rail_power", 1, o_rail_power);
    op(pacc_pkg::PACC_RAIL_CLOSE_LEVEL, 1'b1, 0);
    cmp("rail_level", 0, o_rail_level);
    // clock enable low: an offered op must leave no trace
    @(posedge i_clk);
    i_ce <= 1'b0;
    op(pacc_pkg::PACC_ONES_COMPLEMENT, 1'b1, 0);
    cmp("acc_frozen", 5, o_acc);
    @(posedge i_clk);
    i_ce <= 1'b1;
    op(pacc_pkg::PACC_ONES_COMPLEMENT, 1'b1, 0);
    cmp("acc", 32'hffff_fffa, o_acc);
    complete_run;
  end
endmodule : testbench
